// ### hw/stp_gate_pkg.sv
// Constants, state and frame class types for the per-port spanning tree gate.
// Assumes a single 20 MHz core clock; times are counted in whole seconds.
package stp_gate_pkg;

    // Port states, Gray coded along blocking-listening-learning-forwarding
    typedef enum logic [2:0] {
        ST_BLOCKING = 3'h0,
        ST_LISTENING = 3'h1,
        ST_LEARNING = 3'h3,
        ST_FORWARDING = 3'h2,
        ST_DISABLED = 3'h6
    } port_state_e;

    // Class of a frame arriving from the port's own segment
    typedef enum logic [1:0] {
        FR_DATA = 2'h0,
        FR_BPDU = 2'h1,
        FR_MGMT = 2'h2,
        FR_OTHER = 2'h3
    } frame_class_e;

    // Core clock rate and the one second time base derived from it
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned TICK_PERIOD_MS = 1000;
    localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S * TICK_PERIOD_MS;
    localparam int unsigned TICK_CNT_W = 25;

    // Second counts for timers and BPDU age fields
    localparam int unsigned SEC_W = 8;
    localparam logic [SEC_W-1:0] SEC_ZERO = 8'h00;
    localparam logic [SEC_W-1:0] SEC_LAST = 8'h01;
    localparam logic [SEC_W-1:0] AGE_STEP = 8'h01;
    localparam logic [SEC_W-1:0] AGE_FULL = 8'hff;

endpackage : stp_gate_pkg

// ### hw/stp_port_state_gate.sv
// Per-port spanning tree state controller and frame gate.
// Assumes the fabric, address table and CPU present one-cycle request pulses
// synchronous to clk_sys, and that the CPU gives forward delay and max age.
`timescale 1ns/1ps
module stp_port_state_gate #(
    parameter int unsigned SEC_CYCLES = stp_gate_pkg::TICK_CYCLES // Cycles per second
) (
    input wire logic clk_sys, // Core clock, 20 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire logic stp_enable, // Spanning tree runs on this port
    input wire logic port_enable, // Port administratively enabled
    input wire logic cmd_forward, // Pulse: move toward forwarding
    input wire logic cmd_block, // Pulse: return to blocking
    input wire logic [stp_gate_pkg::SEC_W-1:0] fwd_delay_s, // Forward delay, seconds
    input wire logic [stp_gate_pkg::SEC_W-1:0] max_age_s, // Max age, seconds
    input wire logic rx_valid, // Pulse: frame received from segment
    input wire logic [1:0] rx_class, // Class of received frame
    input wire logic bpdu_superior, // Received BPDU names a better path
    input wire logic [stp_gate_pkg::SEC_W-1:0] bpdu_age, // Age of received BPDU
    input wire logic sw_valid, // Pulse: frame from another port
    input wire logic cpu_bpdu_valid, // Pulse: CPU offers a BPDU to send
    input wire logic [stp_gate_pkg::SEC_W-1:0] cpu_bpdu_age, // Age of CPU BPDU
    output stp_gate_pkg::port_state_e port_state, // Current port state
    output logic learn_en, // Address learning enabled
    output logic fwd_en, // Frame forwarding enabled
    output logic fwd_timer_running, // Forward delay timer counting
    output logic rx_fwd, // Pulse: segment frame forwarded
    output logic rx_drop, // Pulse: segment frame discarded
    output logic sw_fwd, // Pulse: switched frame sent on port
    output logic sw_drop, // Pulse: switched frame discarded
    output logic learn_req, // Pulse: learn source address
    output logic bpdu_to_cpu, // Pulse: received BPDU to CPU
    output logic bpdu_discard, // Pulse: received BPDU dropped
    output logic mgmt_to_cpu, // Pulse: management frame to CPU
    output logic cpu_bpdu_send, // Pulse: CPU BPDU transmitted
    output logic cpu_bpdu_drop, // Pulse: CPU BPDU refused
    output logic [stp_gate_pkg::SEC_W-1:0] cpu_bpdu_age_out // Incremented age sent
);

    localparam int TW = stp_gate_pkg::TICK_CNT_W;
    localparam logic [TW-1:0] TICK_LAST = TW'(SEC_CYCLES - 1);
    localparam logic [TW-1:0] TICK_ZERO = TW'(0);
    localparam logic [TW-1:0] TICK_ONE = TW'(1);

    // Per-state gating decisions
    function automatic logic frames_pass(input stp_gate_pkg::port_state_e st);
        frames_pass = (st == stp_gate_pkg::ST_FORWARDING);
    endfunction : frames_pass

    function automatic logic learning_on(input stp_gate_pkg::port_state_e st);
        learning_on = (st == stp_gate_pkg::ST_LEARNING) || (st == stp_gate_pkg::ST_FORWARDING);
    endfunction : learning_on

    function automatic logic bpdu_cpu_on(input stp_gate_pkg::port_state_e st);
        bpdu_cpu_on = (st != stp_gate_pkg::ST_DISABLED);
    endfunction : bpdu_cpu_on

    function automatic logic bpdu_tx_on(input stp_gate_pkg::port_state_e st);
        bpdu_tx_on = (st == stp_gate_pkg::ST_LEARNING) || (st == stp_gate_pkg::ST_FORWARDING);
    endfunction : bpdu_tx_on

    stp_gate_pkg::port_state_e next_port_state;
    logic [TW-1:0] tick_cnt;
    logic sec_tick;
    logic boot_start;
    logic boot_phase;
    logic rx_data;
    logic rx_bpdu;
    logic rx_mgmt;
    logic bpdu_ok;
    logic bpdu_better;
    logic [stp_gate_pkg::SEC_W-1:0] next_cpu_age;
    logic cpu_age_ok;
    logic enter_timed;
    logic enter_block;
    logic fwd_start;
    logic fwd_stop;
    logic fwd_expired;
    logic loss_start;
    logic loss_expired;

    // Cycle counter of the one second time base
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            tick_cnt <= TICK_ZERO;
        end else if (tick_cnt == TICK_LAST) begin
            tick_cnt <= TICK_ZERO;
        end else begin
            tick_cnt <= tick_cnt + TICK_ONE;
        end
    end

    // One second tick pulse for both timers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= (tick_cnt == TICK_LAST);
        end
    end

    // Boot start pulse, high through reset and for the first cycle after its release
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            boot_start <= 1'b1;
        end else begin
            boot_start <= 1'b0;
        end
    end

    // Boot phase, ended by the first valid BPDU or by leaving blocking
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            boot_phase <= 1'b1;
        end else if (bpdu_ok || port_state != stp_gate_pkg::ST_BLOCKING) begin
            boot_phase <= 1'b0;
        end
    end

    // Classify the received frame and the BPDU age checks
    always_comb begin
        rx_data = rx_valid && (rx_class == stp_gate_pkg::FR_DATA);
        rx_bpdu = rx_valid && (rx_class == stp_gate_pkg::FR_BPDU);
        rx_mgmt = rx_valid && (rx_class == stp_gate_pkg::FR_MGMT);
        bpdu_ok = rx_bpdu && (bpdu_age <= max_age_s);
        bpdu_better = bpdu_ok && bpdu_superior;
        if (cpu_bpdu_age == stp_gate_pkg::AGE_FULL) begin
            next_cpu_age = stp_gate_pkg::AGE_FULL;
        end else begin
            next_cpu_age = cpu_bpdu_age + stp_gate_pkg::AGE_STEP;
        end
        cpu_age_ok = (cpu_bpdu_age != stp_gate_pkg::AGE_FULL) && (next_cpu_age <= max_age_s);
    end

    // Next state of the port
    always_comb begin
        next_port_state = port_state;
        if (!port_enable) begin
            next_port_state = stp_gate_pkg::ST_DISABLED;
        end else if (!stp_enable) begin
            next_port_state = stp_gate_pkg::ST_FORWARDING;
        end else begin
            unique case (port_state)
                stp_gate_pkg::ST_DISABLED: begin
                    next_port_state = stp_gate_pkg::ST_BLOCKING;
                end
                stp_gate_pkg::ST_BLOCKING: begin
                    if (cmd_forward) begin
                        next_port_state = stp_gate_pkg::ST_LISTENING;
                    end else if (boot_phase && fwd_expired) begin
                        next_port_state = stp_gate_pkg::ST_LISTENING;
                    end else if (loss_expired && !bpdu_better) begin
                        next_port_state = stp_gate_pkg::ST_LISTENING;
                    end
                end
                stp_gate_pkg::ST_LISTENING: begin
                    if (bpdu_better || cmd_block) begin
                        next_port_state = stp_gate_pkg::ST_BLOCKING;
                    end else if (fwd_expired) begin
                        next_port_state = stp_gate_pkg::ST_LEARNING;
                    end
                end
                stp_gate_pkg::ST_LEARNING: begin
                    if (cmd_block) begin
                        next_port_state = stp_gate_pkg::ST_BLOCKING;
                    end else if (fwd_expired) begin
                        next_port_state = stp_gate_pkg::ST_FORWARDING;
                    end
                end
                stp_gate_pkg::ST_FORWARDING: begin
                    if (cmd_block || !stp_enable) begin
                        next_port_state = stp_gate_pkg::ST_BLOCKING;
                    end
                end
                default: begin
                    next_port_state = stp_gate_pkg::ST_BLOCKING;
                end
            endcase
        end
    end

    // Port state register, blocking out of reset
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            port_state <= stp_gate_pkg::ST_BLOCKING;
        end else begin
            port_state <= next_port_state;
        end
    end

    // Timer controls derived from state changes
    always_comb begin
        enter_timed = (next_port_state != port_state) &&
            ((next_port_state == stp_gate_pkg::ST_LISTENING) ||
             (next_port_state == stp_gate_pkg::ST_LEARNING));
        enter_block = (next_port_state != port_state) &&
            (next_port_state == stp_gate_pkg::ST_BLOCKING);
        fwd_start = enter_timed || boot_start;
        fwd_stop = enter_block || (next_port_state == stp_gate_pkg::ST_DISABLED) ||
            (next_port_state == stp_gate_pkg::ST_FORWARDING);
        loss_start = bpdu_ok || enter_block || boot_start;
    end

    // Forward delay timer
    stp_sec_timer u_fwd_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(sec_tick),
        .start(fwd_start),
        .stop(fwd_stop),
        .load_value(fwd_delay_s),
        .running(),
        .expired(fwd_expired)
    );

    // BPDU loss timer, held at max age by each valid BPDU
    stp_sec_timer u_loss_timer (
        .clk_sys(clk_sys),
        .rst(rst),
        .tick(sec_tick),
        .start(loss_start),
        .stop(1'b0),
        .load_value(max_age_s),
        .running(),
        .expired(loss_expired)
    );

    // Forward delay running flag as seen outside
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fwd_timer_running <= 1'b0;
        end else if (fwd_start) begin
            fwd_timer_running <= 1'b1;
        end else if (fwd_stop || fwd_expired) begin
            fwd_timer_running <= 1'b0;
        end
    end

    // Address learning level, moves with the state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            learn_en <= 1'b0;
        end else begin
            learn_en <= learning_on(next_port_state);
        end
    end

    // Frame forwarding level, moves with the state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            fwd_en <= 1'b0;
        end else begin
            fwd_en <= frames_pass(next_port_state);
        end
    end

    // Data frame gating for segment traffic
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_fwd <= 1'b0;
            rx_drop <= 1'b0;
        end else begin
            rx_fwd <= rx_data && frames_pass(port_state);
            rx_drop <= rx_data && !frames_pass(port_state);
        end
    end

    // Data frame gating for traffic switched from other ports
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sw_fwd <= 1'b0;
            sw_drop <= 1'b0;
        end else begin
            sw_fwd <= sw_valid && frames_pass(port_state);
            sw_drop <= sw_valid && !frames_pass(port_state);
        end
    end

    // Source address learning on received data frames
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            learn_req <= 1'b0;
        end else begin
            learn_req <= rx_data && learning_on(port_state);
        end
    end

    // Received BPDU steering toward the CPU, aged ones dropped
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            bpdu_to_cpu <= 1'b0;
            bpdu_discard <= 1'b0;
        end else begin
            bpdu_to_cpu <= bpdu_ok && bpdu_cpu_on(port_state);
            bpdu_discard <= rx_bpdu && !(bpdu_ok && bpdu_cpu_on(port_state));
        end
    end

    // Management frames reach the CPU whatever the state
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mgmt_to_cpu <= 1'b0;
        end else begin
            mgmt_to_cpu <= rx_mgmt;
        end
    end

    // CPU supplied BPDU transmit decision
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cpu_bpdu_send <= 1'b0;
            cpu_bpdu_drop <= 1'b0;
        end else begin
            cpu_bpdu_send <= cpu_bpdu_valid && cpu_age_ok && bpdu_tx_on(port_state);
            cpu_bpdu_drop <= cpu_bpdu_valid && !(cpu_age_ok && bpdu_tx_on(port_state));
        end
    end

    // Relayed age of the last offered CPU BPDU
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            cpu_bpdu_age_out <= stp_gate_pkg::SEC_ZERO;
        end else if (cpu_bpdu_valid) begin
            cpu_bpdu_age_out <= next_cpu_age;
        end
    end

endmodule : stp_port_state_gate

// ### hw/stp_sec_timer.sv
// Down counter in whole seconds, stepped by a one second tick.
// Assumes tick is a single-cycle pulse in the clk_sys domain.
`timescale 1ns/1ps
module stp_sec_timer (
    input wire logic clk_sys, // Core clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic tick, // One second tick pulse
    input wire logic start, // Load count and run
    input wire logic stop, // Halt without expiry
    input wire logic [stp_gate_pkg::SEC_W-1:0] load_value, // Seconds to run
    output logic running, // Timer is counting
    output logic expired // One-cycle pulse at expiry
);

    logic [stp_gate_pkg::SEC_W-1:0] count;

    // Count down; start wins over stop, a zero load expires at once
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            count <= stp_gate_pkg::SEC_ZERO;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (start) begin
            count <= load_value;
            running <= (load_value != stp_gate_pkg::SEC_ZERO);
            expired <= (load_value == stp_gate_pkg::SEC_ZERO);
        end else if (stop) begin
            running <= 1'b0;
            expired <= 1'b0;
        end else if (running && tick) begin
            count <= count - stp_gate_pkg::SEC_LAST;
            running <= (count != stp_gate_pkg::SEC_LAST);
            expired <= (count == stp_gate_pkg::SEC_LAST);
        end else begin
            expired <= 1'b0;
        end
    end

endmodule : stp_sec_timer

// ### tb/stp_cpu_model.sv
// Host CPU model: issues state commands and offers BPDUs for transmit.
// Assumes requests change at the falling edge and last one clock cycle.
`timescale 1ns/1ps
module stp_cpu_model (
    input wire logic clk_sys, // Core clock
    input wire logic bpdu_to_cpu, // BPDU delivered up
    output logic cmd_forward = 1'b0, // Toward forwarding
    output logic cmd_block = 1'b0, // Back to blocking
    output logic cpu_bpdu_valid = 1'b0, // BPDU offer
    output logic [7:0] cpu_bpdu_age = 8'h00 // Offered age
);
    int rx_count = 0;

    // Counts BPDUs handed up by the port
    always @(posedge clk_sys) begin
        if (bpdu_to_cpu === 1'b1) begin
            rx_count++;
        end
    end

    // One-cycle command pulse
    task automatic command(input logic fwd);
        @(negedge clk_sys);
        cmd_forward = fwd;
        cmd_block = !fwd;
        @(negedge clk_sys);
        cmd_forward = 1'b0;
        cmd_block = 1'b0;
    endtask : command

    // One-cycle BPDU offer; age is scrambled once the offer ends
    task automatic offer(input logic [7:0] age);
        @(negedge clk_sys);
        cpu_bpdu_valid = 1'b1;
        cpu_bpdu_age = age;
        @(negedge clk_sys);
        cpu_bpdu_valid = 1'b0;
        cpu_bpdu_age = ~age;
    endtask : offer
endmodule : stp_cpu_model

// ### tb/stp_gate_chk.sv
// Concurrent checks on the port state gate, bound to its top module.
// Assumes one clk_sys domain and the asynchronous active high reset rst.
`timescale 1ns/1ps
module stp_gate_chk (
    input wire logic clk_sys, // Core clock
    input wire logic rst, // Reset
    input wire logic stp_enable, // Tree on
    input wire logic port_enable, // Port on
    input wire logic [7:0] max_age_s, // Max age
    input wire logic rx_valid, // Segment frame
    input wire logic [1:0] rx_class, // Frame class
    input wire logic bpdu_superior, // Better path
    input wire logic [7:0] bpdu_age, // BPDU age
    input wire logic cpu_bpdu_valid, // CPU BPDU offer
    input wire logic [7:0] cpu_bpdu_age, // CPU BPDU age
    input wire stp_gate_pkg::port_state_e port_state, // State
    input wire logic fwd_timer_running, // Delay timer
    input wire logic rx_fwd, // Forwarded
    input wire logic rx_drop, // Dropped
    input wire logic learn_req, // Learn
    input wire logic bpdu_to_cpu, // BPDU up
    input wire logic mgmt_to_cpu, // Management up
    input wire logic cpu_bpdu_send, // CPU BPDU out
    input wire logic cpu_bpdu_drop, // CPU BPDU refused
    input wire logic [7:0] cpu_bpdu_age_out // Relayed age
);
    // All checks share the core clock and reset
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    rx_drop_a: assert property (
        rx_valid && rx_class == 2'h0 && port_state != stp_gate_pkg::ST_FORWARDING
        |=> rx_drop && !rx_fwd) else $error("data frame not dropped");
    rx_fwd_a: assert property (
        rx_valid && rx_class == 2'h0 && port_state == stp_gate_pkg::ST_FORWARDING
        |=> rx_fwd && !rx_drop) else $error("data frame not forwarded");
    learn_on_a: assert property (
        rx_valid && rx_class == 2'h0 && (port_state == stp_gate_pkg::ST_LEARNING ||
        port_state == stp_gate_pkg::ST_FORWARDING) |=> learn_req) else $error("no learn");
    mgmt_up_a: assert property (
        rx_valid && rx_class == 2'h2 |=> mgmt_to_cpu) else $error("management frame lost");
    bpdu_off_a: assert property (
        rx_valid && rx_class == 2'h1 && port_state == stp_gate_pkg::ST_DISABLED
        |=> !bpdu_to_cpu) else $error("BPDU passed while disabled");
    cpu_tx_off_a: assert property (
        cpu_bpdu_valid && port_state != stp_gate_pkg::ST_LEARNING &&
        port_state != stp_gate_pkg::ST_FORWARDING |=> cpu_bpdu_drop && !cpu_bpdu_send)
        else $error("CPU BPDU sent while not allowed");
    age_relay_a: assert property (
        cpu_bpdu_valid |=> cpu_bpdu_age_out == (($past(cpu_bpdu_age) == 8'hff) ?
        8'hff : $past(cpu_bpdu_age) + 8'h01)) else $error("relayed age wrong");
    listen_back_a: assert property (
        stp_enable && port_enable && port_state == stp_gate_pkg::ST_LISTENING && rx_valid &&
        rx_class == 2'h1 && bpdu_superior && bpdu_age <= max_age_s
        |=> port_state == stp_gate_pkg::ST_BLOCKING) else $error("listening not left");
    timer_stop_a: assert property (
        port_state == stp_gate_pkg::ST_BLOCKING && $past(port_state) ==
        stp_gate_pkg::ST_LISTENING |-> ##1 !fwd_timer_running) else $error("timer runs");
    port_off_a: assert property (
        !port_enable |=> port_state == stp_gate_pkg::ST_DISABLED) else $error("not disabled");
endmodule : stp_gate_chk

bind stp_port_state_gate stp_gate_chk chk (.clk_sys(clk_sys), .rst(rst),
    .stp_enable(stp_enable), .port_enable(port_enable), .max_age_s(max_age_s),
    .rx_valid(rx_valid), .rx_class(rx_class), .bpdu_superior(bpdu_superior),
    .bpdu_age(bpdu_age), .cpu_bpdu_valid(cpu_bpdu_valid), .cpu_bpdu_age(cpu_bpdu_age),
    .port_state(port_state), .fwd_timer_running(fwd_timer_running), .rx_fwd(rx_fwd),
    .rx_drop(rx_drop), .learn_req(learn_req), .bpdu_to_cpu(bpdu_to_cpu),
    .mgmt_to_cpu(mgmt_to_cpu), .cpu_bpdu_send(cpu_bpdu_send),
    .cpu_bpdu_drop(cpu_bpdu_drop), .cpu_bpdu_age_out(cpu_bpdu_age_out));

// ### tb/stp_port_state_gate_tb_top.sv
// Bench for the port state gate: walks every state and gates frames in each.
// Assumes the CPU model gives commands and CPU BPDUs; the bench drives the rest.
`timescale 1ns/1ps
module stp_port_state_gate_tb_top;
    typedef struct packed {
        logic [9:0] mask;
        logic [9:0] val;
        logic [7:0] age;
    } note_s;
    localparam logic [7:0] MAX_AGE = 8'h03;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic port_enable = 1'b1;
    logic rx_valid = 1'b0;
    logic [1:0] rx_class = 2'h0;
    logic bpdu_superior = 1'b0;
    logic [7:0] bpdu_age = 8'h00;
    logic sw_valid = 1'b0;
    logic cmd_forward, cmd_block, cpu_bpdu_valid, learn_en, fwd_en, fwd_timer_running;
    logic rx_fwd, rx_drop, sw_fwd, sw_drop, learn_req, bpdu_to_cpu, bpdu_discard;
    logic mgmt_to_cpu, cpu_bpdu_send, cpu_bpdu_drop;
    logic [7:0] cpu_bpdu_age, cpu_bpdu_age_out;
    logic [9:0] pulses;
    stp_gate_pkg::port_state_e port_state;
    note_s notes[$];
    note_s nt;
    logic [31:0] rnd = 32'hc34e;
    int failures = 0;
    int n_compared = 0;

    assign pulses = {rx_fwd, rx_drop, sw_fwd, sw_drop, learn_req, bpdu_to_cpu, bpdu_discard,
        mgmt_to_cpu, cpu_bpdu_send, cpu_bpdu_drop};

    stp_port_state_gate #(.SEC_CYCLES(16)) uut (.clk_sys(clk_sys), .rst(rst),
        .stp_enable(1'b1), .port_enable(port_enable), .cmd_forward(cmd_forward),
        .cmd_block(cmd_block), .fwd_delay_s(8'h02), .max_age_s(MAX_AGE),
        .rx_valid(rx_valid), .rx_class(rx_class), .bpdu_superior(bpdu_superior),
        .bpdu_age(bpdu_age), .sw_valid(sw_valid), .cpu_bpdu_valid(cpu_bpdu_valid),
        .cpu_bpdu_age(cpu_bpdu_age), .port_state(port_state), .learn_en(learn_en),
        .fwd_en(fwd_en), .fwd_timer_running(fwd_timer_running), .rx_fwd(rx_fwd),
        .rx_drop(rx_drop), .sw_fwd(sw_fwd), .sw_drop(sw_drop), .learn_req(learn_req),
        .bpdu_to_cpu(bpdu_to_cpu), .bpdu_discard(bpdu_discard), .mgmt_to_cpu(mgmt_to_cpu),
        .cpu_bpdu_send(cpu_bpdu_send), .cpu_bpdu_drop(cpu_bpdu_drop),
        .cpu_bpdu_age_out(cpu_bpdu_age_out));

    stp_cpu_model cpu (.clk_sys(clk_sys), .bpdu_to_cpu(bpdu_to_cpu), .cmd_forward(cmd_forward),
        .cmd_block(cmd_block), .cpu_bpdu_valid(cpu_bpdu_valid), .cpu_bpdu_age(cpu_bpdu_age));

    // Core clock, 50 ns period
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic end_sim();
        $display("compared %0d, failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim

    task automatic cmp(input logic [9:0] got, input logic [9:0] exp, input string msg);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: %s", $time, msg);
        end
    endtask : cmp

    // Bounded wait for a state; a timeout ends the run
    task automatic wait_state(input stp_gate_pkg::port_state_e st);
        for (int i = 0; i < 300 && port_state !== st; i++) @(negedge clk_sys);
        cmp(port_state, st, "state");
        if (port_state !== st) end_sim();
    endtask : wait_state

    // One request of kind k (data, switched, BPDU, management, CPU BPDU) with its note
    task automatic send(input int k, input stp_gate_pkg::port_state_e st, input logic sup,
        input logic [7:0] age);
        logic fw;
        logic ln;
        logic ok;
        logic bp;
        logic [9:0] m;
        logic [9:0] v;
        fw = (st == stp_gate_pkg::ST_FORWARDING);
        ln = fw || (st == stp_gate_pkg::ST_LEARNING);
        ok = ln && age != 8'hff && age + 8'h01 <= MAX_AGE;
        bp = age <= MAX_AGE && st != stp_gate_pkg::ST_DISABLED;
        case (k)
            0: begin m = 10'h320; v = {fw, !fw, 2'h0, ln, 5'h0}; end
            1: begin m = 10'h0c0; v = {2'h0, fw, !fw, 6'h0}; end
            2: begin m = 10'h018; v = {5'h0, bp, !bp, 3'h0}; end
            3: begin m = 10'h004; v = 10'h004; end
            default: begin m = 10'h003; v = {8'h00, ok, !ok}; end
        endcase
        notes.push_back('{m, v, (age == 8'hff) ? 8'hff : age + 8'h01});
        if (k == 4) begin
            cpu.offer(age);
        end else begin
            @(negedge clk_sys);
            rx_valid = (k != 1);
            sw_valid = (k == 1);
            rx_class = (k == 0) ? 2'h0 : ((k == 2) ? 2'h1 : 2'h2);
            bpdu_superior = sup;
            bpdu_age = age;
            @(negedge clk_sys);
            rx_valid = 1'b0;
            sw_valid = 1'b0;
            bpdu_superior = 1'b0;
        end
    endtask : send

    // Every request kind once, random ages
    task automatic burst(input stp_gate_pkg::port_state_e st);
        for (int k = 0; k < 5; k++) begin
            rnd = lfsr(rnd);
            send(k, st, 1'b0, {5'h0, rnd[2:0]});
        end
    endtask : burst

    // Takes the oldest note whenever a result pulse shows
    always @(negedge clk_sys) begin
        if (!rst && (|pulses) === 1'b1) begin
            if (notes.size() == 0) begin
                cmp(pulses, 10'h000, "unexpected pulse");
            end else begin
                nt = notes.pop_front();
                cmp(pulses & nt.mask, nt.val, "gate pulses");
                cmp(pulses & ~nt.mask, 10'h000, "stray pulse");
                if (nt.mask[1]) cmp(cpu_bpdu_age_out, nt.age, "relayed age");
            end
        end
    end

    // Main sequence
    initial begin
        repeat (3) @(negedge clk_sys);
        rst = 1'b0;
        cmp(port_state, stp_gate_pkg::ST_BLOCKING, "reset state");
        cmp({learn_en, fwd_en}, 2'b00, "reset levels");
        wait_state(stp_gate_pkg::ST_LISTENING);
        burst(stp_gate_pkg::ST_LISTENING);
        wait_state(stp_gate_pkg::ST_LEARNING);
        cmp(fwd_timer_running, 1'b1, "timer reload");
        burst(stp_gate_pkg::ST_LEARNING);
        wait_state(stp_gate_pkg::ST_FORWARDING);
        cmp({learn_en, fwd_en}, 2'b11, "forwarding levels");
        burst(stp_gate_pkg::ST_FORWARDING);
        cpu.command(1'b0);
        wait_state(stp_gate_pkg::ST_BLOCKING);
        burst(stp_gate_pkg::ST_BLOCKING);
        cpu.command(1'b1);
        wait_state(stp_gate_pkg::ST_LISTENING);
        send(2, stp_gate_pkg::ST_LISTENING, 1'b1, 8'h00);
        wait_state(stp_gate_pkg::ST_BLOCKING);
        @(negedge clk_sys);
        cmp(fwd_timer_running, 1'b0, "timer stopped");
        repeat (6) begin
            repeat (20) @(negedge clk_sys);
            send(2, stp_gate_pkg::ST_BLOCKING, 1'b1, 8'h01);
            cmp(port_state, stp_gate_pkg::ST_BLOCKING, "held blocked");
        end
        wait_state(stp_gate_pkg::ST_LISTENING);
        port_enable = 1'b0;
        wait_state(stp_gate_pkg::ST_DISABLED);
        burst(stp_gate_pkg::ST_DISABLED);
        port_enable = 1'b1;
        wait_state(stp_gate_pkg::ST_BLOCKING);
        repeat (4) @(negedge clk_sys);
        cmp(notes.size(), 10'h000, "missing results");
        end_sim();
    end
endmodule : stp_port_state_gate_tb_top
